// File: deb_bus.v
// External memory and port bus sequencer with synchronised reset input.
`timescale 1ns/1ps
`include "deb_defs.vh"
module deb_bus
(
  input  wire                  i_core_clk,
  input  wire                  i_rst,
  input  wire                  i_ce,
  input  wire                  i_reset_in_low,
  input  wire [1:0]            i_op,
  input  wire [`DEB_AW-1:0]    i_op_addr,
  input  wire [`DEB_DW-1:0]    i_op_wdata,
  input  wire                  i_op_jump,
  input  wire [`DEB_AW-1:0]    i_op_target,
  input  wire [`DEB_DW-1:0]    i_data_in,
  output reg                   o_cycle_clock_out,
  output reg                   o_program_mem_strobe_n,
  output reg                   o_port_read_strobe_n,
  output reg                   o_write_strobe_n,
  output reg  [`DEB_AW-1:0]    o_addr,
  output reg  [`DEB_DW-1:0]    o_data_out,
  output reg                   o_data_oe_n,
  output reg  [`DEB_DW-1:0]    o_rdata,
  output reg                   o_rdata_valid,
  output reg                   o_cycle_start,
  output reg  [`DEB_AW-1:0]    o_pc,
  output reg                   o_running,
  output reg  [2:0]            o_rst_low_cycles
);
  wire               rst_low_s;     // Synchronised reset pin level, active low.
  reg  [1:0]         phase_r;       // Quarter of the cycle clock.
  reg  [1:0]         op_r;          // Access kind of the running cycle.
  reg  [`DEB_DW-1:0] data_in_r;     // Data pins sampled once, before logic uses them.
  reg  [`DEB_DW-1:0] data_in_s;     // Second stage of the data pin sampling.
  reg                hold_r;        // Held until the first phase 3 after release, then running resumes.
  reg                clr_pend_r;    // One full cycle still to pass after assertion.

  // Strobe that fits a given access kind.
  function [2:0] strobe_sel;
    input [1:0] op;
    begin
      case (op)
        `DEB_OP_FETCH: strobe_sel = `DEB_STB_PROG;
        `DEB_OP_TBLR:  strobe_sel = `DEB_STB_PROG;
        `DEB_OP_IN:    strobe_sel = `DEB_STB_PORT;
        default:       strobe_sel = `DEB_STB_WR;
      endcase
    end
  endfunction

  // The reset pin can move anywhere in a cycle, so it is synchronised.
  deb_sync u_rst_sync
  (
    .i_clk (i_core_clk),
    .i_rst (i_rst),
    .i_ce  (i_ce),
    .i_d   (i_reset_in_low),
    .o_q   (rst_low_s)
  );

  // Data pins come from outside; two flops before capture. The pins are
  // sampled while a read strobe is low and the word reaches data_in_s two
  // clocks later, so it is taken at the edge where the strobe rises. Taking it
  // any earlier would catch the released bus from before the strobe fell.
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      data_in_r <= `DEB_ZERO16;
      data_in_s <= `DEB_ZERO16;
    end
    else if (i_ce)
    begin
      data_in_r <= i_data_in;
      data_in_s <= data_in_r;
    end
  end

  // Divide the master clock by four; phase 0 is the cycle clock falling edge.
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      phase_r           <= `DEB_PH0;
      o_cycle_clock_out <= 1'b0;
    end
    else if (i_ce)
    begin
      phase_r           <= phase_r + `DEB_PH_STEP;
      o_cycle_clock_out <= (phase_r == `DEB_PH1) || (phase_r == `DEB_PH2);
    end
  end

  // Bus sequencer. A cycle starts at phase 0, the strobe falls at phase 1
  // (the write strobe half a cycle in, at phase 2), the program counter steps
  // at phase 3 and every strobe rises at the next phase 0, where the read word
  // sampled under the strobe is handed over and the address moves on.
  // The address and the strobes change on one edge, which gives zero hold;
  // a slow pad would need an extra quarter cycle here.
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_program_mem_strobe_n <= 1'b1;
      o_port_read_strobe_n   <= 1'b1;
      o_write_strobe_n       <= 1'b1;
      o_addr                 <= `DEB_ZERO16;
      o_data_out             <= `DEB_ZERO16;
      o_data_oe_n            <= 1'b1;
      o_rdata                <= `DEB_ZERO16;
      o_rdata_valid          <= 1'b0;
      o_cycle_start          <= 1'b0;
      o_pc                   <= `DEB_ZERO16;
      o_running              <= 1'b0;
      o_rst_low_cycles       <= `DEB_CNT_ZERO;
      op_r                   <= `DEB_OP_FETCH;
      hold_r                 <= 1'b1;
      clr_pend_r             <= 1'b0;
    end
    else if (i_ce)
    begin
      o_rdata_valid <= 1'b0;
      o_cycle_start <= 1'b0;
      if (!rst_low_s)
      begin
        // Strobes forced high and data released at once. A write cut here may
        // leave a wrong address on the pins; the partner must accept that.
        o_program_mem_strobe_n <= 1'b1;
        o_port_read_strobe_n   <= 1'b1;
        o_write_strobe_n       <= 1'b1;
        o_data_oe_n            <= 1'b1;
        o_running              <= 1'b0;
        hold_r                 <= 1'b1;
        if (phase_r == `DEB_PH3)
        begin
          // Count phase 3 edges seen low, the first cycle even if partial; the partner must reach five.
          if (o_rst_low_cycles != `DEB_RST_HOLD_CYC)
            o_rst_low_cycles <= o_rst_low_cycles + `DEB_CNT_ONE;
          // Clearing waits for the next complete cycle after assertion.
          if (clr_pend_r)
          begin
            o_addr <= `DEB_ZERO16;
            o_pc   <= `DEB_ZERO16;
          end
          clr_pend_r <= 1'b1;
        end
      end
      else
      begin
        clr_pend_r <= 1'b0;
        if (hold_r)
        begin
          // Wait for the first phase 3 after release before fetching again.
          o_rst_low_cycles <= `DEB_CNT_ZERO;
          if (phase_r == `DEB_PH3)
          begin
            hold_r    <= 1'b0;
            o_running <= 1'b1;
          end
        end
        else
        begin
          case (phase_r)
            `DEB_PH0:
            begin
              // A read strobe still low here means a read is ending; its word
              // was sampled under the strobe, before the strobe rises.
              if (!o_program_mem_strobe_n || !o_port_read_strobe_n)
              begin
                o_rdata       <= data_in_s;
                o_rdata_valid <= 1'b1;
              end
              // Strobe rises and address moves on this same edge, so the address
              // has zero hold after the strobe.
              o_program_mem_strobe_n <= 1'b1;
              o_port_read_strobe_n   <= 1'b1;
              o_write_strobe_n       <= 1'b1;
              o_data_oe_n            <= 1'b1;
              op_r                   <= i_op;
              o_cycle_start          <= 1'b1;
              o_addr                 <= (i_op == `DEB_OP_FETCH) ? o_pc : i_op_addr;
              o_data_out             <= i_op_wdata;
            end
            `DEB_PH1:
            begin
              // One strobe only, chosen by the access kind.
              o_program_mem_strobe_n <= strobe_sel(op_r) != `DEB_STB_PROG;
              o_port_read_strobe_n   <= strobe_sel(op_r) != `DEB_STB_PORT;
              o_data_oe_n            <= op_r != `DEB_OP_WRITE;
            end
            `DEB_PH2:
            begin
              // The write strobe falls half a cycle in.
              o_write_strobe_n <= op_r != `DEB_OP_WRITE;
            end
            default:
            begin
              // Next fetch address; a jump replaces the step. Table reads,
              // port input and writes leave the counter alone.
              if (op_r == `DEB_OP_FETCH)
                o_pc <= i_op_jump ? i_op_target : o_pc + `DEB_PC_STEP;
            end
          endcase
        end
      end
    end
  end
endmodule

// File: deb_defs.vh
// Constants for the external bus sequencer and its reset handling.
`ifndef DEB_DEFS_VH
`define DEB_DEFS_VH
`define DEB_AW            16
`define DEB_DW            16
`define DEB_PORTW         3
`define DEB_ZERO16        16'h0000
`define DEB_ONES16        16'hFFFF
`define DEB_DIV_LAST      2'h3
`define DEB_PH0           2'h0
`define DEB_PH1           2'h1
`define DEB_PH2           2'h2
`define DEB_PH3           2'h3
`define DEB_RST_HOLD_CYC  3'h5
`define DEB_CNT_ZERO      3'h0
`define DEB_CNT_ONE       3'h1
`define DEB_OP_FETCH      2'h0
`define DEB_OP_TBLR       2'h1
`define DEB_OP_IN         2'h2
`define DEB_OP_WRITE      2'h3
`define DEB_STB_PROG      3'h6
`define DEB_STB_PORT      3'h5
`define DEB_STB_WR        3'h3
`define DEB_PH_STEP       2'h1
`define DEB_PC_STEP       16'h0001
`endif

// File: deb_sync.v
// Two flip-flop synchroniser for a level coming from outside the clock domain.
`timescale 1ns/1ps
module deb_sync
(
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_ce,
  input  wire i_d,
  output wire o_q
);
  reg meta_r; // First stage, read only by the second stage.
  reg sync_r; // Second stage, safe to use.

  // Reset value is high: the level synchronised here is active low.
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end
    else if (i_ce)
    begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;
endmodule

// File: deb_sva.sv
// Checker for the bus sequencer's strobe, reset and cycle rules.
`timescale 1ns/1ps
module deb_sva
(
  input wire        i_core_clk,
  input wire        i_rst,
  input wire        i_reset_in_low,
  input wire        o_cycle_clock_out,
  input wire        o_program_mem_strobe_n,
  input wire        o_port_read_strobe_n,
  input wire        o_write_strobe_n,
  input wire [15:0] o_addr,
  input wire        o_data_oe_n,
  input wire        o_rdata_valid,
  input wire [15:0] o_pc,
  input wire        o_running
);
  // Both read strobes high, and all three strobes high.
  wire rd_n = o_program_mem_strobe_n & o_port_read_strobe_n;
  wire idle = rd_n & o_write_strobe_n;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_one_strobe: assert property (
    $countones(~{o_program_mem_strobe_n, o_port_read_strobe_n, o_write_strobe_n}) <= 1)
    else $error("two strobes low at once");
  chk_reset_quiet: assert property (
    (!i_reset_in_low)[*3] |=> idle && o_data_oe_n)
    else $error("bus not quiet under pin reset");
  chk_reset_clear: assert property (
    (!i_reset_in_low)[*8] ##1 (!i_reset_in_low)[*4] |-> o_pc == 16'h0000 && o_addr == 16'h0000)
    else $error("address or counter not cleared");
  chk_resume_run: assert property (
    $rose(i_reset_in_low) |-> ##[1:12] o_running)
    else $error("execution did not resume");
  chk_clock_div: assert property (
    $rose(o_cycle_clock_out) |=> o_cycle_clock_out ##1 !o_cycle_clock_out ##1
    !o_cycle_clock_out ##1 o_cycle_clock_out)
    else $error("cycle clock not master over four");
  chk_addr_hold: assert property (
    !idle && $past(!idle) |-> $stable(o_addr))
    else $error("address moved under a strobe");
  chk_read_capture: assert property (
    o_rdata_valid |-> !$past(rd_n))
    else $error("read data taken after strobe rose");
  chk_drive_write: assert property (
    !o_data_oe_n |-> rd_n)
    else $error("data driven during a read");
endmodule
bind deb_bus deb_sva i_sva (.*);

// File: deb_mem_model.sv
// Behavioural external memory and ports behind the read strobes.
`timescale 1ns/1ps
module deb_mem_model
(
  input  wire        i_clk,
  input  wire        i_rd_n,
  input  wire [15:0] i_addr,
  output wire [15:0] o_data
);
  // A released bus changes every cycle so no read passes by luck.
  reg [15:0] junk_r = 16'h5A5A;
  always @(posedge i_clk)
    junk_r <= ~junk_r;
  // Writes are ignored, so a cut write with a bad address does no harm.
  assign o_data = i_rd_n ? junk_r : {~i_addr[7:0], ~i_addr[15:8]};
endmodule

// File: tb_top.sv
// Self-checking bench for the external bus sequencer.
`timescale 1ns/1ps
`include "deb_defs.vh"
module tb_top;
  reg         clk   = 1'b0;
  reg         rst   = 1'b1;
  reg         pin_n = 1'b1;
  reg  [1:0]  op    = `DEB_OP_FETCH;
  reg  [15:0] oa    = 16'h0000;
  reg         jmp   = 1'b0;
  reg  [15:0] tgt   = 16'h0000;
  wire [2:0]  lowc;
  wire [15:0] din, addr, dout, rdat, pc;
  wire        m_n, p_n, w_n, oe_n, vld, cst, run;
  integer     num_errors  = 0;
  integer     checks_done = 0;
  integer     i;
  always #4 clk = ~clk;
  deb_bus i_dut (.i_core_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_reset_in_low(pin_n),
    .i_op(op), .i_op_addr(oa), .i_op_wdata(~oa), .i_op_jump(jmp),
    .i_op_target(tgt), .i_data_in(din), .o_cycle_clock_out(),
    .o_program_mem_strobe_n(m_n), .o_port_read_strobe_n(p_n), .o_write_strobe_n(w_n),
    .o_addr(addr), .o_data_out(dout), .o_data_oe_n(oe_n), .o_rdata(rdat),
    .o_rdata_valid(vld), .o_cycle_start(cst), .o_pc(pc), .o_running(run),
    .o_rst_low_cycles(lowc));
  deb_mem_model i_mem (.i_clk(clk), .i_rd_n(m_n & p_n), .i_addr(addr), .o_data(din));
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      num_errors = num_errors + 1;
      $display("mismatch %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task stop_test;
  begin
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  // Returns at the falling edge just after a cycle start, at once if one has
  // just started; a start that never comes counts as a mismatch.
  task wait_cs;
    integer n;
  begin
    n = 0;
    while (cst !== 1'b1 && n < 40) @(negedge clk) n = n + 1;
    chk("start", 16'h0001, {15'h0000, cst});
  end
  endtask
  // Judges a cycle that just started; sb is the expected strobe set. The read
  // word shows at the next cycle start, so this returns just after that start.
  task cyc(input [15:0] a, input [2:0] sb);
  begin
    repeat (2) @(negedge clk);
    chk("strobe", {13'h0000, sb}, {13'h0000, m_n, p_n, w_n});
    chk("addr", a, addr);
    chk("oe_n", {15'h0000, sb[0]}, {15'h0000, oe_n});
    if (!sb[0])
      chk("wdata", ~a, dout);
    repeat (2) @(negedge clk);
    if (sb[0])
      chk("rdata", {~a[7:0], ~a[15:8]}, rdat);
    chk("valid", {15'h0000, sb[0]}, {15'h0000, vld});
  end
  endtask
  // The access is queued at one cycle start and runs in the next.
  task access(input [1:0] k, input [15:0] a, input [2:0] sb);
  begin
    wait_cs;
    op = k;
    oa = a;
    @(negedge clk);
    wait_cs;
    cyc(a, sb);
  end
  endtask
  // Pin reset lands while the write strobe is still low.
  task s_reset;
    integer n;
  begin
    access(`DEB_OP_WRITE, 16'hBEEF, 3'b110);
    op = `DEB_OP_FETCH;
    pin_n = 1'b0;
    repeat (20) @(negedge clk);
    chk("quiet", 16'h000F, {11'h000, run, m_n, p_n, w_n, oe_n});
    chk("pc", 16'h0000, pc);
    chk("addr0", 16'h0000, addr);
    chk("lowcyc", 16'h0005, {13'h0000, lowc});
    pin_n = 1'b1;
    n = 0;
    while (run !== 1'b1 && n < 16) @(negedge clk) n = n + 1;
    chk("run", 16'h0001, {15'h0000, run});
    wait_cs;
    cyc(16'h0000, 3'b011);
  end
  endtask
  // Straight-line fetches from address zero after the first reset release.
  task s_fetch;
  begin
    for (i = 0; i < 3; i = i + 1)
    begin
      wait_cs;
      cyc(i[15:0], 3'b011);
    end
  end
  endtask
  // A jump taken in a fetch cycle moves the next fetch to the target.
  task s_jump;
  begin
    wait_cs;
    jmp = 1'b1;
    tgt = 16'h1234;
    @(negedge clk);
    wait_cs;
    jmp = 1'b0;
    cyc(16'h1234, 3'b011);
  end
  endtask
  initial
  begin
    #20000;
    num_errors = num_errors + 1;
    stop_test;
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    s_fetch;
    s_jump;
    access(`DEB_OP_TBLR, 16'hFFFF, 3'b011);
    access(`DEB_OP_IN, 16'h0005, 3'b101);
    s_reset;
    stop_test;
  end
endmodule
